// file: hdl/input_capture_unit.sv
// Input capture unit with two timers, pin logic and AXI4-Lite registers
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module input_capture_unit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic capture_pin_in,
  output logic capture_pin_out,
  output logic capture_pin_oe,
  input wire logic timer_ext_clock_in,
  output logic timer_osc_oe,
  output logic irq
);
  import capture_pkg::*;
  `include "capture_cfg.svh"

  typedef struct packed {
    capture_pkg::wr_state_t wr;
    capture_pkg::rd_state_t rd;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic arready;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] mode;
    logic [15:0] capture_value;
    logic flag;
    logic irq_enable;
    logic [7:0] t1_ctl;
    logic [7:0] t3_ctl;
    logic [7:0] port_latch;
    logic [7:0] port_c_direction;
    logic [3:0] prescale;
    logic pin_out;
    logic pin_oe;
    logic osc_oe;
    logic irq;
  } unit_state_t;
  unit_state_t s_reg;
  unit_state_t s_next;

  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic ext_rise;
  logic [15:0] timer_one_count;
  logic [15:0] timer_three_count;
  logic t1_load;
  logic t3_load;
  logic do_write;
  logic [31:0] wr_val;

  // Pin value as seen by the capture logic: latch when driven, else the input
  assign pin_level = s_reg.pin_oe ? s_reg.pin_out : capture_pin_in;

  edge_sync u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  edge_sync u_ext_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(timer_ext_clock_in),
    .rise(ext_rise),
    .fall()
  );

  // Write strobes for direct timer loads
  assign do_write = s_reg.aw_have & s_reg.w_have & (s_reg.wr == WR_IDLE);
  assign wr_val = s_reg.w_data;
  assign t1_load = do_write & (s_reg.aw_addr == `OFS_TIMER_ONE_COUNT);
  assign t3_load = do_write & (s_reg.aw_addr == `OFS_TIMER_THREE_COUNT);

  // Both timers share clock select semantics; async mode is treated as synced
  timer16 #(.WIDTH(16)) u_timer_one (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(s_reg.t1_ctl[`TCTL_ON_BIT]),
    .clock_select(s_reg.t1_ctl[`TCTL_CS_BIT]),
    .ext_rise(ext_rise),
    .load(t1_load),
    .load_value(wr_val[15:0]),
    .count(timer_one_count)
  );

  timer16 #(.WIDTH(16)) u_timer_three (
    .clk_sys(clk_sys),
    .rst(rst),
    .enable(s_reg.t3_ctl[`TCTL_ON_BIT]),
    .clock_select(s_reg.t3_ctl[`TCTL_CS_BIT]),
    .ext_rise(ext_rise),
    .load(t3_load),
    .load_value(wr_val[15:0]),
    .count(timer_three_count)
  );

  // Capture, prescaler, registers and bus handshakes
  always_comb begin
    logic cap_mode;
    logic event_hit;
    logic flag_clr;
    logic [7:0] ra;
    s_next = s_reg;
    cap_mode = (s_reg.mode[3:2] == 2'b01);
    event_hit = 1'b0;
    flag_clr = 1'b0;
    ra = s_axi_araddr;

    // Event qualification per mode
    if (!cap_mode) begin
      s_next.prescale = 4'h0;
    end else begin
      case (s_reg.mode)
        `MODE_CAP_FALL: event_hit = pin_fall;
        `MODE_CAP_RISE: event_hit = pin_rise;
        `MODE_CAP_RISE4: begin
          if (pin_rise) begin
            s_next.prescale = s_reg.prescale + 4'h1;
            event_hit = (s_reg.prescale[1:0] == 2'(`PRESCALE_4));
          end
        end
        default: begin
          if (pin_rise) begin
            s_next.prescale = s_reg.prescale + 4'h1;
            event_hit = (s_reg.prescale == `PRESCALE_16);
          end
        end
      endcase
    end
    if (event_hit) begin
      // Overwrite without protection; timer chosen by timer three control
      s_next.capture_value = s_reg.t3_ctl[`TCTL_SRC_BIT] ? timer_three_count
                                                         : timer_one_count;
    end

    // Write channel: accept address and data in either order
    s_next.awready = 1'b0;
    s_next.wready = 1'b0;
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    case (s_reg.wr)
      WR_IDLE: begin
        s_next.awready = !s_next.aw_have && !(s_axi_awvalid && s_reg.awready);
        s_next.wready = !s_next.w_have && !(s_axi_wvalid && s_reg.wready);
        if (do_write) begin
          s_next.bresp = `RESP_OKAY;
          if (s_reg.w_strb[0]) begin
            if (s_reg.aw_addr == `OFS_CAPTURE_CONTROL) begin
              s_next.mode = wr_val[3:0];
            end else if (s_reg.aw_addr == `OFS_CAPTURE_VALUE) begin
              s_next.capture_value[7:0] = wr_val[7:0];
            end else if (s_reg.aw_addr == `OFS_FLAG_REG_ONE) begin
              flag_clr = wr_val[`CAPTURE_FLAG_BIT];
            end else if (s_reg.aw_addr == `OFS_IRQ_ENABLE) begin
              s_next.irq_enable = wr_val[`CAPTURE_FLAG_BIT];
            end else if (s_reg.aw_addr == `OFS_TIMER_ONE_CONTROL) begin
              s_next.t1_ctl = wr_val[7:0];
            end else if (s_reg.aw_addr == `OFS_TIMER_THREE_CONTROL) begin
              s_next.t3_ctl = wr_val[7:0];
            end else if (s_reg.aw_addr == `OFS_PORT_C) begin
              s_next.port_latch = wr_val[7:0];
            end else if (s_reg.aw_addr != `OFS_TIMER_ONE_COUNT &&
                         s_reg.aw_addr != `OFS_TIMER_THREE_COUNT) begin
              s_next.bresp = `RESP_SLVERR;
            end
          end
          if (s_reg.w_strb[1]) begin
            if (s_reg.aw_addr == `OFS_CAPTURE_VALUE) begin
              s_next.capture_value[15:8] = wr_val[15:8];
            end else if (s_reg.aw_addr == `OFS_PORT_C) begin
              s_next.port_c_direction = wr_val[15:8];
            end
          end
          s_next.aw_have = 1'b0;
          s_next.w_have = 1'b0;
          s_next.wr = WR_RESP;
        end
      end
      default: begin
        if (s_axi_bready) begin
          s_next.wr = WR_IDLE;
          s_next.awready = 1'b1;
          s_next.wready = 1'b1;
        end
      end
    endcase

    // Sticky flag: set beats a simultaneous clear
    if (event_hit) begin
      s_next.flag = 1'b1;
    end else if (flag_clr) begin
      s_next.flag = 1'b0;
    end

    // Read channel
    s_next.arready = 1'b0;
    case (s_reg.rd)
      RD_IDLE: begin
        s_next.arready = 1'b1;
        if (s_axi_arvalid && s_reg.arready) begin
          s_next.arready = 1'b0;
          s_next.rd = RD_RESP;
          s_next.rresp = `RESP_OKAY;
          s_next.rdata = 32'h0000_0000;
          if (ra == `OFS_CAPTURE_CONTROL) begin
            s_next.rdata[3:0] = s_reg.mode;
          end else if (ra == `OFS_CAPTURE_VALUE) begin
            s_next.rdata[15:0] = s_reg.capture_value;
          end else if (ra == `OFS_FLAG_REG_ONE) begin
            s_next.rdata[`CAPTURE_FLAG_BIT] = s_reg.flag;
          end else if (ra == `OFS_IRQ_ENABLE) begin
            s_next.rdata[`CAPTURE_FLAG_BIT] = s_reg.irq_enable;
          end else if (ra == `OFS_TIMER_ONE_CONTROL) begin
            s_next.rdata[7:0] = s_reg.t1_ctl;
          end else if (ra == `OFS_TIMER_THREE_CONTROL) begin
            s_next.rdata[7:0] = s_reg.t3_ctl;
          end else if (ra == `OFS_TIMER_ONE_COUNT) begin
            s_next.rdata[15:0] = timer_one_count;
          end else if (ra == `OFS_TIMER_THREE_COUNT) begin
            s_next.rdata[15:0] = timer_three_count;
          end else if (ra == `OFS_PORT_C) begin
            s_next.rdata[7:0] = s_reg.port_latch;
            s_next.rdata[2] = capture_pin_in;
            if (s_reg.t1_ctl[`TCTL_ON_BIT]) begin
              s_next.rdata[1:0] = 2'b00;
            end
            s_next.rdata[15:8] = s_reg.port_c_direction;
          end else begin
            s_next.rresp = `RESP_SLVERR;
          end
        end
      end
      default: begin
        if (s_axi_rready) begin
          s_next.rd = RD_IDLE;
          s_next.arready = 1'b1;
        end
      end
    endcase

    // Pin drivers and interrupt
    s_next.pin_out = s_next.port_latch[2];
    s_next.pin_oe = ~s_next.port_c_direction[2];
    s_next.osc_oe = ~s_next.t1_ctl[`TCTL_ON_BIT] & ~s_next.port_c_direction[0];
    s_next.irq = s_next.flag & s_next.irq_enable;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.port_c_direction <= `PORT_C_DIR_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = (s_reg.wr == WR_RESP);
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = (s_reg.rd == RD_RESP);
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign capture_pin_out = s_reg.pin_out;
  assign capture_pin_oe = s_reg.pin_oe;
  assign timer_osc_oe = s_reg.osc_oe;
  assign irq = s_reg.irq;
endmodule // input_capture_unit

// file: inc/capture_cfg.svh
// Register offsets, field positions, reset values and timing constants for the capture unit
`ifndef CAPTURE_CFG_SVH
`define CAPTURE_CFG_SVH
`define OFS_CAPTURE_CONTROL 8'h00
`define OFS_CAPTURE_VALUE 8'h04
`define OFS_FLAG_REG_ONE 8'h08
`define OFS_IRQ_ENABLE 8'h0C
`define OFS_TIMER_ONE_CONTROL 8'h10
`define OFS_TIMER_THREE_CONTROL 8'h14
`define OFS_TIMER_ONE_COUNT 8'h18
`define OFS_TIMER_THREE_COUNT 8'h1C
`define OFS_PORT_C 8'h20
`define CAPTURE_FLAG_BIT 2
`define TCTL_ON_BIT 0
`define TCTL_CS_BIT 1
`define TCTL_NSYNC_BIT 2
`define TCTL_SRC_BIT 6
`define MODE_OFF 4'h0
`define MODE_CAP_FALL 4'h4
`define MODE_CAP_RISE 4'h5
`define MODE_CAP_RISE4 4'h6
`define MODE_CAP_RISE16 4'h7
`define PRESCALE_4 4'h3
`define PRESCALE_16 4'hF
`define INSTR_DIV 2'h3
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define PORT_C_DIR_RESET 8'hFF
`endif

// file: inc/capture_pkg.sv
// Types shared by the capture unit modules
package capture_pkg;
  typedef enum logic [1:0] {TIMER_MODE, SYNC_COUNTER, ASYNC_COUNTER} timer_mode_t;
  typedef enum logic {RD_IDLE, RD_RESP} rd_state_t;
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_t;
endpackage

// file: hdl/edge_sync.sv
// Two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ns
module edge_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic din,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;
  sync_state_t s_reg;
  sync_state_t s_next;

  // Shift the pin through two flops, then keep the previous synced value
  always_comb begin
    s_next = s_reg;
    s_next.meta = din;
    s_next.sync = s_reg.meta;
    s_next.last = s_reg.sync;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Edges only from the synchronised copy
  assign rise = s_reg.sync & ~s_reg.last;
  assign fall = ~s_reg.sync & s_reg.last;
endmodule // edge_sync

// file: hdl/timer16.sv
// 16-bit timer with instruction-rate or external-edge clocking
`timescale 1ns/1ns
module timer16 #(
  parameter int WIDTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable,
  input wire logic clock_select,
  input wire logic ext_rise,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_value,
  output logic [WIDTH-1:0] count
);
  `include "capture_cfg.svh"
  typedef struct packed {
    logic [1:0] div;
    logic [WIDTH-1:0] count;
  } timer_state_t;
  timer_state_t s_reg;
  timer_state_t s_next;

  // Advance once per instruction cycle or on each external rising edge
  always_comb begin
    s_next = s_reg;
    s_next.div = s_reg.div + 2'h1;
    if (load) begin
      s_next.count = load_value;
    end else if (enable) begin
      if (clock_select) begin
        if (ext_rise) begin
          s_next.count = s_reg.count + WIDTH'(1);
        end
      end else if (s_reg.div == `INSTR_DIV) begin
        s_next.count = s_reg.count + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.count;
endmodule // timer16

// file: sim/input_capture_unit_asserts.sv
// Register port timing checks for the capture unit
`timescale 1ns/1ns
module capture_unit_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Handshakes that start a write or a read
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after request");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00 || s_axi_bresp == 2'b10)
    else $error("illegal write response code");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_read_quiet: assert property (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid)
    else $error("read data without request");
endmodule // capture_unit_asserts

// file: sim/pin_source.sv
// External event source driving the capture pin with whole pulses
`timescale 1ns/1ns
module pin_source (
  input wire logic clk_sys,
  output logic pin
);
  initial pin = 1'b0;
  // One high phase then one low phase, each held for gap clocks
  task automatic pulse(input int gap);
    @(posedge clk_sys);
    pin <= 1'b1;
    repeat (gap) @(posedge clk_sys);
    pin <= 1'b0;
    repeat (gap) @(posedge clk_sys);
  endtask
endmodule // pin_source

// file: sim/tb_input_capture_unit.sv
// Self-checking bench for the input capture unit
`timescale 1ns/1ns
module tb_input_capture_unit;
  logic clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic capture_pin_in, capture_pin_out, capture_pin_oe, src_pin, timer_ext_clock_in, timer_osc_oe;
  int miscompares, total_checks, seed, mode, pre_cnt, sel;
  logic [15:0] t1, t3, exp_cap;
  logic exp_flag, exp_en;
  // Pin level: the unit's own driver wins while enabled
  assign capture_pin_in = capture_pin_oe ? capture_pin_out : src_pin;
  input_capture_unit u_dut (.*);
  pin_source u_src (.clk_sys(clk_sys), .pin(src_pin));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rd_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Reference model of one pin edge
  task automatic model_edge(input bit rise);
    bit hit;
    hit = (mode == 4 && !rise) || (mode == 5 && rise);
    if (rise && (mode == 6 || mode == 7)) begin
      pre_cnt = (pre_cnt + 1) % 16;
      hit = (mode == 6) ? (pre_cnt % 4 == 0) : (pre_cnt == 0);
    end
    if (hit) begin
      exp_flag = 1'b1;
      exp_cap = sel ? t3 : t1;
    end
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      u_src.pulse(6 + ($random(seed) & 3));
      model_edge(1'b1);
      model_edge(1'b0);
    end
  endtask
  task automatic set_mode(input int m);
    wr(8'h00, m);
    mode = m;
    if (m < 4 || m > 7) pre_cnt = 0;
    wr(8'h08, 32'h0000_0004);
    exp_flag = 1'b0;
  endtask
  task automatic load1();
    t1 = 16'($random(seed));
    wr(8'h18, {16'h0000, t1});
  endtask
  task automatic check_state();
    rd(8'h08);
    chk(rd_data & 32'h0000_0004, {29'h0, exp_flag, 2'h0}, "flag");
    rd(8'h04);
    chk(rd_data & 32'h0000_FFFF, {16'h0000, exp_cap}, "capture");
    chk(irq, exp_flag & exp_en, "irq");
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
  // Main sequence
  initial begin
    seed = 71454;
    {miscompares, total_checks, mode, pre_cnt, sel} = '0;
    {exp_cap, exp_flag, exp_en, t3} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    timer_ext_clock_in = 1'b0;
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'h20);
    chk(rd_data, 32'h0000_FF00, "port reset");
    wr(8'h20, 32'h0000_FE03);
    rd(8'h20);
    chk(rd_data, 32'h0000_FE03, "port off");
    chk(timer_osc_oe, 1'b1, "osc oe off");
    wr(8'h10, 32'h0000_0003);
    wr(8'h14, 32'h0000_0003);
    rd(8'h20);
    chk(rd_data, 32'h0000_FE00, "port on");
    chk(timer_osc_oe, 1'b0, "osc oe on");
    wr(8'h0C, 32'h0000_0004);
    exp_en = 1'b1;
    load1();
    repeat (3) begin
      @(posedge clk_sys);
      timer_ext_clock_in <= 1'b1;
      repeat (4) @(posedge clk_sys);
      timer_ext_clock_in <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    t1 = t1 + 16'h0003;
    rd(8'h18);
    chk(rd_data & 32'h0000_FFFF, {16'h0000, t1}, "timer");
    // Quarter rate: two samples forty clocks apart differ by ten counts
    wr(8'h10, 32'h0000_0001);
    rd(8'h18);
    t1 = rd_data[15:0] + 16'h000A;
    repeat (37) @(posedge clk_sys);
    rd(8'h18);
    chk(rd_data & 32'h0000_FFFF, {16'h0000, t1}, "quarter rate");
    wr(8'h10, 32'h0000_0003);
    for (int m = 4; m < 8; m++) begin
      set_mode(0);
      set_mode(m);
      load1();
      pulses(m == 6 ? 3 : m == 7 ? 15 : 1);
      check_state();
      load1();
      pulses(1);
      check_state();
    end
    set_mode(6);
    pulses(2);
    set_mode(7);
    pulses(13);
    check_state();
    pulses(1);
    check_state();
    wr(8'h0C, 32'h0000_0000);
    exp_en = 1'b0;
    check_state();
    wr(8'h0C, 32'h0000_0004);
    exp_en = 1'b1;
    set_mode(0);
    set_mode(5);
    wr(8'h14, 32'h0000_0043);
    sel = 1;
    repeat (2) begin
      t3 = 16'($random(seed));
      wr(8'h1C, {16'h0000, t3});
      pulses(1);
    end
    check_state();
    wr(8'h20, 32'h0000_F803);
    wr(8'h20, 32'h0000_F807);
    model_edge(1'b1);
    chk({capture_pin_oe, capture_pin_out}, 2'b11, "pin drive");
    // Let the latch edge pass the synchroniser before reading the flag
    repeat (4) @(posedge clk_sys);
    check_state();
    rd(8'h40);
    chk(rd_resp, 2'b10, "read resp");
    wr(8'h40, 32'h0000_0001);
    chk(rd_resp, 2'b10, "write resp");
    print_verdict();
  end
endmodule // tb_input_capture_unit
bind input_capture_unit capture_unit_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
